// ==== gpio_wired_or_defs.vh ====
// Constants for the dual port wired-OR general purpose I/O block
`ifndef GPIO_WIRED_OR_DEFS_VH
`define GPIO_WIRED_OR_DEFS_VH
// Register indices; byte address is four times the index
`define IDX_PORT_A 8'h00
`define IDX_PORT_B 8'h01
`define IDX_PORT_CFG 8'h03
`define IDX_PORT_A_DIR 8'h04
`define IDX_PORT_B_DIR 8'h05
// Configuration register fields
`define CFG_BANK_SEL 0
`define CFG_B_WOI_EN 1
`define CFG_B_PD_EN 2
`define CFG_SLEEP 3
`define CFG_TIMER_SEL 4
`define CFG_WOI_FLAG 5
// Reset values
`define RST_DIR 8'h00
`define RST_CFG 5'h00
// AXI answers
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// ==== gpio_wired_or.v ====
// Dual 8-bit GPIO ports with wired-OR interrupt detection, AXI4-Lite slave
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ns
// Notes on behaviour
// [RULE1] Sixteen lines as two independent 8-bit bidirectional ports.
// [RULE2] Direction bit one makes a pin output, zero makes it input.
// [RULE3] Reset clears every direction register so all pins are inputs.
// [RULE4] Reset leaves the port A and port B data latches unchanged.
// [RULE5] Data writes always update the output latch, even for inputs.
// [RULE6] Output pins drive the latch value.
// [RULE7] Reading an input bit returns the pin level.
// [RULE8] Reading an output bit returns the latch, not the pin.
// [RULE9] Bank select maps index 0 and 4 to interrupt and pull-down enables.
// [RULE10] Reset clears the bank select so data and direction show.
// [RULE11] Port A interrupt enable bit arms detection on its line.
// [RULE12] Port A pull-down enable bit turns on that line's pull-down.
// [RULE13] Port A interrupt enables act for inputs and outputs alike.
// [RULE14] Configuration bits 1 and 2 are port B group interrupt and pull-down.
// [RULE15] Port B detection covers only pins configured as inputs.
// [RULE16] Configuration bit 4 gives the shared pin to the timer compare output.
// [RULE17] Reset clears configuration bits 0, 1, 2 and 4; sleep bit 3 keeps following the pin.
// [RULE18] Detection sets the flag; enabled ports then raise an interrupt request.
// [RULE19] Writing zero to the flag clears it.
// [RULE20] A status bit shows the controller sleep state.
// [RULE21] Software loads data before setting direction to avoid glitches.
// [RULE22] Writing one to the flag keeps it; sleep bit ignores writes.
`include "gpio_wired_or_defs.vh"

module gpio_wired_or #(
  parameter WIDTH = 8 // [RULE1]
) (
  input wire aclk,
  input wire aresetn,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [WIDTH-1:0] port_a_in,
  output wire [WIDTH-1:0] port_a_out,
  output wire [WIDTH-1:0] port_a_oe_n,
  output wire [WIDTH-1:0] port_a_pulldown,
  input wire [WIDTH-1:0] port_b_in,
  output wire [WIDTH-1:0] port_b_out,
  output wire [WIDTH-1:0] port_b_oe_n,
  output wire [WIDTH-1:0] port_b_pulldown,
  input wire timer_compare_output,
  input wire can_sleep_in,
  output wire wired_or_interrupt_req
);

  // ==========================================================
  // Registers
  reg [WIDTH-1:0] port_a_pin_data_reg;
  reg [WIDTH-1:0] port_b_pin_data_reg;
  reg [WIDTH-1:0] port_a_direction_reg;
  reg [WIDTH-1:0] port_b_direction_reg;
  reg [WIDTH-1:0] port_a_interrupt_enable_reg;
  reg [WIDTH-1:0] port_a_pulldown_enable_reg;
  reg port_a_bank_select_reg;
  reg port_b_group_interrupt_enable_reg;
  reg port_b_pulldown_enable_reg;
  reg timer_pin_select_reg;
  reg wired_or_interrupt_flag_reg;
  reg [WIDTH-1:0] pa_sync1_reg;
  reg [WIDTH-1:0] pa_sync2_reg;
  reg [WIDTH-1:0] pb_sync1_reg;
  reg [WIDTH-1:0] pb_sync2_reg;
  reg sleep_sync1_reg;
  reg sleep_sync2_reg;
  reg [WIDTH-1:0] pa_prev_reg;
  reg [WIDTH-1:0] pb_prev_reg;
  reg [31:0] awaddr_reg;
  reg aw_held_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  reg w_held_reg;

  // ==========================================================
  // Pin synchronisers
  always @(posedge aclk) begin
    pa_sync1_reg <= port_a_in;
    pa_sync2_reg <= pa_sync1_reg;
    pb_sync1_reg <= port_b_in;
    pb_sync2_reg <= pb_sync1_reg;
    sleep_sync1_reg <= can_sleep_in;
    sleep_sync2_reg <= sleep_sync1_reg;
    pa_prev_reg <= pa_sync2_reg;
    pb_prev_reg <= pb_sync2_reg;
  end

  // ==========================================================
  // Pin drive
  // Port B bit 7 handed to the timer when selected
  wire [WIDTH-1:0] pb_timer_mask = timer_pin_select_reg ? {1'b1, {(WIDTH-1){1'b0}}} :
    {WIDTH{1'b0}};
  assign port_a_out = port_a_pin_data_reg; // [RULE6]
  assign port_a_oe_n = ~port_a_direction_reg; // [RULE2]
  assign port_b_out = (port_b_pin_data_reg & ~pb_timer_mask) |
    ({WIDTH{timer_compare_output}} & pb_timer_mask); // [RULE16]
  assign port_b_oe_n = ~(port_b_direction_reg | pb_timer_mask); // [RULE2]
  assign port_a_pulldown = port_a_pulldown_enable_reg; // [RULE12]
  assign port_b_pulldown = {WIDTH{port_b_pulldown_enable_reg}} & ~pb_timer_mask; // [RULE14]

  // Readback mixes pin and latch per direction bit
  wire [WIDTH-1:0] port_a_read = (port_a_direction_reg & port_a_pin_data_reg) |
    (~port_a_direction_reg & pa_sync2_reg); // [RULE7] [RULE8]
  wire [WIDTH-1:0] port_b_read = (port_b_direction_reg & port_b_pin_data_reg) |
    (~port_b_direction_reg & pb_sync2_reg); // [RULE7] [RULE8]

  // ==========================================================
  // Wired-OR detection
  // Wired-OR lines are active low: a falling edge is the event
  wire [WIDTH-1:0] pa_fall = pa_prev_reg & ~pa_sync2_reg;
  wire [WIDTH-1:0] pb_fall = pb_prev_reg & ~pb_sync2_reg;
  wire pa_event = |(pa_fall & port_a_interrupt_enable_reg); // [RULE11] [RULE13]
  wire pb_event = port_b_group_interrupt_enable_reg &
    |(pb_fall & ~port_b_direction_reg & ~pb_timer_mask); // [RULE15] [RULE16]
  wire woi_event = pa_event | pb_event;
  wire any_woi_enabled = (|port_a_interrupt_enable_reg) | port_b_group_interrupt_enable_reg;
  assign wired_or_interrupt_req = wired_or_interrupt_flag_reg & any_woi_enabled; // [RULE18]

  // ==========================================================
  // AXI4-Lite write path
  assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held_reg & ~s_axi_bvalid;
  wire aw_have = aw_held_reg | (s_axi_awvalid & s_axi_awready);
  wire w_have = w_held_reg | (s_axi_wvalid & s_axi_wready);
  wire [31:0] wr_addr = aw_held_reg ? awaddr_reg : s_axi_awaddr;
  wire [31:0] wr_data = w_held_reg ? wdata_reg : s_axi_wdata;
  wire [3:0] wr_strb = w_held_reg ? wstrb_reg : s_axi_wstrb;
  wire wr_fire = aw_have & w_have & ~s_axi_bvalid;
  wire wr_lane = wr_fire & wr_strb[0];
  wire [7:0] wr_idx = wr_addr[9:2];
  wire wr_hit = (wr_addr[1:0] == 2'b00) && (wr_addr[31:10] == 22'h000000) &&
    ((wr_idx == `IDX_PORT_A) || (wr_idx == `IDX_PORT_B) || (wr_idx == `IDX_PORT_CFG) ||
    (wr_idx == `IDX_PORT_A_DIR) || (wr_idx == `IDX_PORT_B_DIR));
  wire we_a = wr_lane && wr_hit && (wr_idx == `IDX_PORT_A);
  wire we_b = wr_lane && wr_hit && (wr_idx == `IDX_PORT_B);
  wire we_cfg = wr_lane && wr_hit && (wr_idx == `IDX_PORT_CFG);
  wire we_a_dir = wr_lane && wr_hit && (wr_idx == `IDX_PORT_A_DIR);
  wire we_b_dir = wr_lane && wr_hit && (wr_idx == `IDX_PORT_B_DIR);

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 32'h00000000;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready && !wr_fire) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready && !wr_fire) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Data latches: no reset term, they keep their contents
  always @(posedge aclk) begin
    if (we_a && !port_a_bank_select_reg) begin
      port_a_pin_data_reg <= wr_data[WIDTH-1:0]; // [RULE4] [RULE5]
    end
    if (we_b) begin
      port_b_pin_data_reg <= wr_data[WIDTH-1:0]; // [RULE4] [RULE5]
    end
  end

  // ==========================================================
  // Control registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      port_a_direction_reg <= `RST_DIR; // [RULE3]
      port_b_direction_reg <= `RST_DIR; // [RULE3]
      port_a_interrupt_enable_reg <= `RST_DIR;
      port_a_pulldown_enable_reg <= `RST_DIR;
      {timer_pin_select_reg, port_b_pulldown_enable_reg,
        port_b_group_interrupt_enable_reg, port_a_bank_select_reg} <= 4'h0; // [RULE10] [RULE17]
      wired_or_interrupt_flag_reg <= 1'b0;
    end else begin
      if (we_a && port_a_bank_select_reg) begin
        port_a_interrupt_enable_reg <= wr_data[WIDTH-1:0]; // [RULE9]
      end
      if (we_a_dir) begin
        if (port_a_bank_select_reg) begin
          port_a_pulldown_enable_reg <= wr_data[WIDTH-1:0]; // [RULE9]
        end else begin
          port_a_direction_reg <= wr_data[WIDTH-1:0]; // [RULE2]
        end
      end
      if (we_b_dir) begin
        port_b_direction_reg <= wr_data[WIDTH-1:0]; // [RULE2]
      end
      if (we_cfg) begin
        port_a_bank_select_reg <= wr_data[`CFG_BANK_SEL];
        port_b_group_interrupt_enable_reg <= wr_data[`CFG_B_WOI_EN]; // [RULE14]
        port_b_pulldown_enable_reg <= wr_data[`CFG_B_PD_EN]; // [RULE14]
        timer_pin_select_reg <= wr_data[`CFG_TIMER_SEL]; // [RULE16]
      end
      // A new event wins over a clearing write
      if (woi_event) begin
        wired_or_interrupt_flag_reg <= 1'b1; // [RULE18]
      end else if (we_cfg && !wr_data[`CFG_WOI_FLAG]) begin
        wired_or_interrupt_flag_reg <= 1'b0; // [RULE19] [RULE22]
      end
    end
  end

  // ==========================================================
  // AXI4-Lite read path
  assign s_axi_arready = ~s_axi_rvalid;
  wire [7:0] rd_idx = s_axi_araddr[9:2];
  wire rd_ok = (s_axi_araddr[1:0] == 2'b00) && (s_axi_araddr[31:10] == 22'h000000);
  reg [7:0] rd_val;
  reg rd_hit;

  always @* begin
    rd_val = 8'h00;
    rd_hit = rd_ok;
    if (rd_idx == `IDX_PORT_A) begin
      rd_val = port_a_bank_select_reg ? port_a_interrupt_enable_reg : port_a_read; // [RULE9]
    end else if (rd_idx == `IDX_PORT_B) begin
      rd_val = port_b_read;
    end else if (rd_idx == `IDX_PORT_CFG) begin
      rd_val = {2'b00, wired_or_interrupt_flag_reg, timer_pin_select_reg,
        sleep_sync2_reg, port_b_pulldown_enable_reg,
        port_b_group_interrupt_enable_reg, port_a_bank_select_reg}; // [RULE20]
    end else if (rd_idx == `IDX_PORT_A_DIR) begin
      rd_val = port_a_bank_select_reg ? port_a_pulldown_enable_reg : port_a_direction_reg;
    end else if (rd_idx == `IDX_PORT_B_DIR) begin
      rd_val = port_b_direction_reg;
    end else begin
      rd_hit = 1'b0;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= (rd_hit && rd_ok) ? {24'h000000, rd_val} : 32'h00000000;
      s_axi_rresp <= (rd_hit && rd_ok) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // gpio_wired_or

// ==== gpio_pins_model.sv ====
// Pin-side circuitry model: resolves each line from block drive and outside source
`timescale 1ns/1ns
module gpio_pins_model (
  input wire [7:0] out,
  input wire [7:0] oe_n,
  input wire [7:0] ext_val,
  output wire [7:0] level
);
  // Outside source yields wherever the block drives the line
  assign level = (~oe_n & out) | (oe_n & ext_val);
endmodule // gpio_pins_model

// ==== gpio_wired_or_properties.sv ====
// Concurrent checks on the bus handshake and pin control outputs
`timescale 1ns/1ns
module gpio_wired_or_checker #(
  parameter WIDTH = 8
) (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [WIDTH-1:0] port_a_oe_n,
  input wire [WIDTH-1:0] port_b_oe_n,
  input wire [WIDTH-1:0] port_b_pulldown,
  input wire wired_or_interrupt_req
);
  // ==========================================
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_reset_inputs: assert property ($rose(aresetn) |->
    &port_a_oe_n && &port_b_oe_n && !(|port_b_pulldown)) else $error("pins not released");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> s_axi_bvalid) else $error("write not answered");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  a_dir_by_write: assert property ($changed({port_a_oe_n, port_b_oe_n}) |->
    $rose(s_axi_bvalid)) else $error("direction moved without a write");
  a_group_pulldown: assert property (&port_b_pulldown[WIDTH-2:0] ||
    !(|port_b_pulldown[WIDTH-2:0])) else $error("group pull-down split");
  a_flag_clear: assert property ($fell(wired_or_interrupt_req) |->
    $rose(s_axi_bvalid)) else $error("request dropped without a write");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_irq: cover property ($rose(wired_or_interrupt_req));
endmodule // gpio_wired_or_checker
bind gpio_wired_or gpio_wired_or_checker #(.WIDTH(WIDTH)) i_chk (.*);

// ==== gpio_wired_or_test.sv ====
// Self-checking bench for the dual port wired-OR GPIO block
`timescale 1ns/1ns
module gpio_wired_or_test;
  logic aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic timer_compare_output = 1'h0, can_sleep_in = 1'h1;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
  logic [3:0] s_axi_wstrb = 4'hF;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire wired_or_interrupt_req;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [7:0] port_a_in, port_a_out, port_a_oe_n, port_a_pulldown;
  wire [7:0] port_b_in, port_b_out, port_b_oe_n, port_b_pulldown;
  int fails = 0, checks = 0, cyc = 0;
  typedef struct packed {logic [7:0] wi, wv, ri, re;} row_t;
  // Data goes in before direction so outputs never glitch
  row_t rows [8] = '{
    '{8'h00, 8'h5A, 8'h00, 8'h33}, '{8'h04, 8'hF0, 8'h00, 8'h53},
    '{8'h01, 8'hC3, 8'h01, 8'h0F}, '{8'h05, 8'hFF, 8'h01, 8'hC3},
    '{8'h03, 8'h01, 8'h03, 8'h09}, '{8'h00, 8'h81, 8'h00, 8'h81},
    '{8'h04, 8'h0F, 8'h04, 8'h0F}, '{8'h03, 8'h00, 8'h04, 8'hF0}};
  always #10 aclk = ~aclk;
  gpio_wired_or #(.WIDTH(8)) i_dut (.*);
  gpio_pins_model i_pa (.out(port_a_out), .oe_n(port_a_oe_n), .ext_val(8'h33), .level(port_a_in));
  gpio_pins_model i_pb (.out(port_b_out), .oe_n(port_b_oe_n), .ext_val(8'h0F), .level(port_b_in));
  // ==========================================
  // Tasks
  task automatic ck(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d, input logic [1:0] er);
    bit a = 1, w = 1, b = 1;
    @(posedge aclk);
    s_axi_awaddr <= {22'h0, i, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (a || w || b) begin
      @(posedge aclk);
      if (a && s_axi_awready) begin
        a = 0;
        s_axi_awvalid <= 1'h0;
      end
      if (w && s_axi_wready) begin
        w = 0;
        s_axi_wvalid <= 1'h0;
      end
      if (b && s_axi_bvalid) begin
        b = 0;
        s_axi_bready <= 1'h0;
        ck({30'h0, s_axi_bresp}, {30'h0, er});
      end
    end
  endtask
  task automatic rd(input logic [7:0] i, input logic [7:0] e, input logic [1:0] er);
    bit a = 1, r = 1;
    @(posedge aclk);
    s_axi_araddr <= {22'h0, i, 2'h0};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (a || r) begin
      @(posedge aclk);
      if (a && s_axi_arready) begin
        a = 0;
        s_axi_arvalid <= 1'h0;
      end
      if (r && s_axi_rvalid) begin
        r = 0;
        s_axi_rready <= 1'h0;
        ck({s_axi_rdata[31:0]}, {24'h0, e});
        ck({30'h0, s_axi_rresp}, {30'h0, er});
      end
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Hang guard, far above the roughly 130 cycles the tests need
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      wrap_up;
    end
  end
  // ==========================================
  // Sequence
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    wr(8'h03, 8'h01, 2'h0);
    wr(8'h00, 8'h00, 2'h0);
    wr(8'h04, 8'h00, 2'h0);
    wr(8'h03, 8'h00, 2'h0);
    foreach (rows[k]) begin
      wr(rows[k].wi, rows[k].wv, 2'h0);
      rd(rows[k].ri, rows[k].re, 2'h0);
    end
    ck({16'h0, port_a_oe_n, port_a_pulldown}, 32'h0F0F);
    // Enabled line is an output here: its fall must still count
    wr(8'h00, 8'hDA, 2'h0);
    wr(8'h00, 8'h5A, 2'h0);
    repeat (4) @(posedge aclk);
    ck({31'h0, wired_or_interrupt_req}, 32'h1);
    rd(8'h03, 8'h28, 2'h0);
    wr(8'h03, 8'h20, 2'h0);
    ck({31'h0, wired_or_interrupt_req}, 32'h1);
    wr(8'h03, 8'h00, 2'h0);
    ck({31'h0, wired_or_interrupt_req}, 32'h0);
    wr(8'h03, 8'h16, 2'h0);
    timer_compare_output <= 1'h1;
    repeat (2) @(posedge aclk);
    ck({22'h0, port_b_out[7], port_b_oe_n[7], port_b_pulldown}, 32'h27F);
    // Falling port B outputs must not count while the group enable is on
    wr(8'h01, 8'h00, 2'h0);
    repeat (4) @(posedge aclk);
    ck({31'h0, wired_or_interrupt_req}, 32'h0);
    wr(8'h01, 8'hC3, 2'h0);
    rd(8'h03, 8'h1E, 2'h0);
    rd(8'h02, 8'h00, 2'h2);
    wr(8'h02, 8'h55, 2'h2);
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    ck({port_a_oe_n, port_b_oe_n, port_a_out, port_b_out}, 32'hFFFF5AC3);
    rd(8'h03, 8'h08, 2'h0);
    rd(8'h04, 8'h00, 2'h0);
    wrap_up;
  end
endmodule // gpio_wired_or_test
